// [src/dual_memory_and_control_move.sv]
// Decode and execution of the dual X/Y memory move and the control register move.
// Assumes memories answer reads combinationally in the cycle the request is shown.
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module dual_memory_and_control_move #(
  parameter int STACK_DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [23:0] instr_word,
  input wire logic [23:0] instr_ext,
  input wire logic growth_det,
  input wire logic limit_det,
  output logic [23:0] x_mem_addr,
  output logic x_mem_rd,
  output logic x_mem_wr,
  output logic [23:0] x_mem_wdata,
  input wire logic [23:0] x_mem_rdata,
  output logic [23:0] y_mem_addr,
  output logic y_mem_rd,
  output logic y_mem_wr,
  output logic [23:0] y_mem_wdata,
  input wire logic [23:0] y_mem_rdata,
  output logic move_done,
  output logic y_io_dropped,
  input wire logic [5:0] sw_addr,
  input wire logic [23:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [23:0] sw_rdata
);
  localparam int SP_W = $clog2(STACK_DEPTH);

  if (STACK_DEPTH < 2 || STACK_DEPTH > 256 || (1 << SP_W) != STACK_DEPTH) begin : g_chk
    $error("STACK_DEPTH must be a power of two from 2 to 256");
  end

  // ----------------------------------------------------------------------
  // Storage and read view
  // ----------------------------------------------------------------------
  move_pkg::word_t rf_reg [32];
  move_pkg::word_t stack_hi_reg [STACK_DEPTH];
  move_pkg::word_t stack_lo_reg [STACK_DEPTH];
  move_pkg::word_t rv [32];
  move_pkg::state_t state_reg;
  logic [SP_W-1:0] sp_idx;
  logic accept;
  logic exec;

  assign sp_idx = rf_reg[move_pkg::IDX_SP][SP_W-1:0];
  assign instr_ready = (state_reg == move_pkg::ST_IDLE);
  assign accept = instr_valid & instr_ready;
  assign exec = (state_reg == move_pkg::ST_EXEC);

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      rv[i] = rf_reg[i];
    end
    rv[move_pkg::IDX_SSH] = stack_hi_reg[sp_idx];
    rv[move_pkg::IDX_SSL] = stack_lo_reg[sp_idx];
  end

  // ----------------------------------------------------------------------
  // Address units
  // ----------------------------------------------------------------------
  ea_if x_ea ();
  ea_if y_ea ();
  ea_unit u_x_ea (.ea(x_ea));
  ea_unit u_y_ea (.ea(y_ea));

  logic is_dual;
  logic [2:0] xr;
  logic [2:0] yr;
  logic [2:0] cmode;
  assign is_dual = instr_word[move_pkg::F_DUAL];
  assign xr = instr_word[move_pkg::F_PTR +: 3];
  // The Y pointer always comes from the bank the X pointer does not use.
  assign yr = {~xr[2], instr_word[move_pkg::F_YR +: 2]};
  assign cmode = instr_word[move_pkg::F_CMODE +: 3];

  always_comb begin
    x_ea.ptr = rv[{2'b00, xr}];
    x_ea.offset = rv[{2'b01, xr}];
    x_ea.ext = instr_ext;
    x_ea.mode = is_dual ? {1'b0, instr_word[move_pkg::F_XMODE +: 2]} : cmode;
    y_ea.ptr = rv[{2'b00, yr}];
    y_ea.offset = rv[{2'b01, yr}];
    y_ea.ext = instr_ext;
    y_ea.mode = {1'b0, instr_word[move_pkg::F_YMODE +: 2]};
  end

  // ----------------------------------------------------------------------
  // Decode of the next execute cycle
  // ----------------------------------------------------------------------
  logic x_rd_next, x_wr_next, y_rd_next, y_wr_next;
  move_pkg::word_t x_addr_next, y_addr_next, x_wdata_next, y_wdata_next;
  logic dx_en_next, dy_en_next, c_en_next, c_mem_next, c_space_next, dec_next, drop_next;
  move_pkg::idx_t dx_next, dy_next, c_dst_next;
  move_pkg::word_t c_data_next, m_addr;
  logic xptr_we, yptr_we, cw;
  move_pkg::idx_t cidx, oidx;

  always_comb begin
    x_rd_next = 1'b0;
    x_wr_next = 1'b0;
    y_rd_next = 1'b0;
    y_wr_next = 1'b0;
    x_addr_next = x_ea.addr;
    y_addr_next = y_ea.addr;
    x_wdata_next = 24'h000000;
    y_wdata_next = 24'h000000;
    dx_en_next = 1'b0;
    dy_en_next = 1'b0;
    dx_next = move_pkg::IDX_X0;
    dy_next = move_pkg::IDX_Y0;
    c_dst_next = move_pkg::IDX_X0;
    c_en_next = 1'b0;
    c_mem_next = 1'b0;
    c_space_next = instr_word[move_pkg::F_SPACE];
    c_data_next = 24'h000000;
    dec_next = 1'b0;
    drop_next = 1'b0;
    xptr_we = 1'b0;
    yptr_we = 1'b0;
    cw = instr_word[move_pkg::F_CW];
    cidx = instr_word[move_pkg::F_CIDX +: 5];
    oidx = instr_word[move_pkg::F_OIDX +: 5];
    m_addr = {18'h00000, instr_word[move_pkg::F_ABS +: move_pkg::ABS_SHORT_W]};
    if (is_dual) begin
      dx_next = instr_word[move_pkg::F_EE + 1] ? {4'hA, instr_word[move_pkg::F_EE]}
                                              : {4'h8, instr_word[move_pkg::F_EE]};
      dy_next = instr_word[move_pkg::F_FF + 1] ? {4'hA, instr_word[move_pkg::F_FF]}
                                              : {4'h9, instr_word[move_pkg::F_FF]};
      drop_next = (x_ea.addr >= move_pkg::IO_BASE) && (y_ea.addr >= move_pkg::IO_BASE);
      // Sources are sampled now, before any write of this instruction lands.
      x_wdata_next = rv[dx_next];
      y_wdata_next = rv[dy_next];
      x_rd_next = instr_word[move_pkg::F_XW];
      x_wr_next = ~instr_word[move_pkg::F_XW];
      y_rd_next = instr_word[move_pkg::F_YW] & ~drop_next;
      y_wr_next = ~instr_word[move_pkg::F_YW] & ~drop_next;
      dx_en_next = x_rd_next;
      dy_en_next = y_rd_next;
      xptr_we = 1'b1;
      yptr_we = 1'b1;
    end else begin
      unique case (instr_word[move_pkg::F_FORM +: 2])
        move_pkg::FORM_REG: begin
          c_en_next = 1'b1;
          c_dst_next = cw ? cidx : oidx;
          c_data_next = cw ? rv[oidx] : rv[cidx];
          dec_next = cw ? (oidx == move_pkg::IDX_SSH) : (cidx == move_pkg::IDX_SSH);
        end
        move_pkg::FORM_IMM: begin
          c_en_next = cw;
          c_dst_next = cidx;
          c_data_next = {16'h0000, instr_word[move_pkg::F_IMM +: move_pkg::SHORT_IMM_W]};
        end
        default: begin
          if (instr_word[move_pkg::F_FORM +: 2] == move_pkg::FORM_EA) begin
            m_addr = x_ea.addr;
            xptr_we = (cmode != move_pkg::EA_ABS) && (cmode != move_pkg::EA_IMM);
          end
          c_dst_next = cidx;
          if (instr_word[move_pkg::F_FORM +: 2] == move_pkg::FORM_EA &&
              cmode == move_pkg::EA_IMM) begin
            c_en_next = cw;
            c_data_next = instr_ext;
          end else begin
            c_en_next = cw;
            c_mem_next = cw;
            dec_next = ~cw && (cidx == move_pkg::IDX_SSH);
            x_rd_next = cw & ~c_space_next;
            x_wr_next = ~cw & ~c_space_next;
            y_rd_next = cw & c_space_next;
            y_wr_next = ~cw & c_space_next;
            x_addr_next = m_addr;
            y_addr_next = m_addr;
            x_wdata_next = rv[cidx];
            y_wdata_next = rv[cidx];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Execute stage registers
  // ----------------------------------------------------------------------
  logic dual_reg, dx_en_reg, dy_en_reg, c_en_reg, c_mem_reg, c_space_reg, dec_reg, last_drop_reg;
  move_pkg::idx_t dx_reg, dy_reg, c_dst_reg;
  move_pkg::word_t c_data_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= move_pkg::ST_IDLE;
    end else if (accept) begin
      state_reg <= move_pkg::ST_EXEC;
    end else begin
      state_reg <= move_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      x_mem_rd <= 1'b0;
      x_mem_wr <= 1'b0;
      y_mem_rd <= 1'b0;
      y_mem_wr <= 1'b0;
      x_mem_addr <= 24'h000000;
      y_mem_addr <= 24'h000000;
      x_mem_wdata <= 24'h000000;
      y_mem_wdata <= 24'h000000;
      y_io_dropped <= 1'b0;
    end else begin
      x_mem_rd <= accept & x_rd_next;
      x_mem_wr <= accept & x_wr_next;
      y_mem_rd <= accept & y_rd_next;
      y_mem_wr <= accept & y_wr_next;
      y_io_dropped <= accept & drop_next;
      if (accept) begin
        x_mem_addr <= x_addr_next;
        y_mem_addr <= y_addr_next;
        x_mem_wdata <= x_wdata_next;
        y_mem_wdata <= y_wdata_next;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dual_reg <= 1'b0;
      dx_en_reg <= 1'b0;
      dy_en_reg <= 1'b0;
      c_en_reg <= 1'b0;
      c_mem_reg <= 1'b0;
      c_space_reg <= 1'b0;
      dec_reg <= 1'b0;
      dx_reg <= move_pkg::IDX_X0;
      dy_reg <= move_pkg::IDX_Y0;
      c_dst_reg <= move_pkg::IDX_X0;
      c_data_reg <= 24'h000000;
    end else if (accept) begin
      dual_reg <= is_dual;
      dx_en_reg <= dx_en_next;
      dy_en_reg <= dy_en_next;
      c_en_reg <= c_en_next;
      c_mem_reg <= c_mem_next;
      c_space_reg <= c_space_next;
      dec_reg <= dec_next;
      dx_reg <= dx_next;
      dy_reg <= dy_next;
      c_dst_reg <= c_dst_next;
      c_data_reg <= c_data_next;
    end
  end

  assign move_done = exec;

  // ----------------------------------------------------------------------
  // Write back
  // ----------------------------------------------------------------------
  move_pkg::word_t wb_data, sp_new;
  logic inc, load_sr;
  logic [7:0] cc_new;
  logic [SP_W-1:0] ssh_wr_idx;

  assign wb_data = c_mem_reg ? (c_space_reg ? y_mem_rdata : x_mem_rdata) : c_data_reg;
  assign inc = c_en_reg && (c_dst_reg == move_pkg::IDX_SSH);
  assign load_sr = ~dual_reg && c_en_reg && (c_dst_reg == move_pkg::IDX_SR);
  // Read-then-decrement, then increment-then-write, so SYSTEM_STACK_HIGH_WORD to SYSTEM_STACK_HIGH_WORD keeps SP.
  assign sp_new = rf_reg[move_pkg::IDX_SP] + {23'h000000, inc} - {23'h000000, dec_reg};
  assign ssh_wr_idx = sp_new[SP_W-1:0];

  cc_unit u_cc (
    .cc_old(rf_reg[move_pkg::IDX_SR][7:0]),
    .src_byte(wb_data[7:0]),
    .load_all(load_sr),
    .growth(growth_det),
    .limit(limit_det),
    .cc_new(cc_new)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) begin
        rf_reg[i] <= move_pkg::RF_RESET;
      end
    end else begin
      if (sw_wr && !sw_addr[5]) begin
        rf_reg[sw_addr[4:0]] <= sw_wdata;
      end
      if (accept && xptr_we) begin
        rf_reg[{2'b00, xr}] <= x_ea.ptr_next;
      end
      if (accept && yptr_we) begin
        rf_reg[{2'b00, yr}] <= y_ea.ptr_next;
      end
      if (exec) begin
        rf_reg[move_pkg::IDX_SP] <= sp_new;
        rf_reg[move_pkg::IDX_SR][7:0] <= cc_new;
        // X is written last so that it wins a forbidden same-register pair.
        if (dy_en_reg) begin
          rf_reg[dy_reg] <= y_mem_rdata;
        end
        if (dx_en_reg) begin
          rf_reg[dx_reg] <= x_mem_rdata;
        end
        if (c_en_reg) begin
          rf_reg[c_dst_reg] <= wb_data;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_hi_reg[i] <= 24'h000000;
        stack_lo_reg[i] <= 24'h000000;
      end
    end else begin
      if (sw_wr && sw_addr == {1'b0, move_pkg::IDX_SSH}) begin
        stack_hi_reg[sp_idx] <= sw_wdata;
      end
      if (sw_wr && sw_addr == {1'b0, move_pkg::IDX_SSL}) begin
        stack_lo_reg[sp_idx] <= sw_wdata;
      end
      if (exec && inc) begin
        stack_hi_reg[ssh_wr_idx] <= wb_data;
      end
      if (exec && c_en_reg && c_dst_reg == move_pkg::IDX_SSL) begin
        stack_lo_reg[sp_idx] <= wb_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_drop_reg <= 1'b0;
    end else if (exec) begin
      last_drop_reg <= y_io_dropped;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sw_rdata <= 24'h000000;
    end else if (sw_rd) begin
      if (!sw_addr[5]) begin
        sw_rdata <= rv[sw_addr[4:0]];
      end else if (sw_addr == move_pkg::SW_STATUS) begin
        sw_rdata <= {22'h000000, last_drop_reg, exec};
      end else begin
        sw_rdata <= 24'h000000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  y_io_drop_a: assert property (y_io_dropped |-> !y_mem_rd && !y_mem_wr &&
      x_mem_addr >= move_pkg::IO_BASE && y_mem_addr >= move_pkg::IO_BASE)
    else $error("Y peripheral access not dropped");
  one_instr_a: assert property (accept |=> move_done && !instr_ready ##1 instr_ready)
    else $error("move did not finish in one execute cycle");
  bank_split_a: assert property (accept && is_dual |=> y_mem_addr == $past(
      rf_reg[{2'b00, ~instr_word[move_pkg::F_PTR + 2], instr_word[move_pkg::F_YR +: 2]}]))
    else $error("dual move Y address not from the opposite pointer bank");
  old_source_a: assert property (accept && is_dual && !instr_word[move_pkg::F_XW]
      |=> x_mem_wr && x_mem_wdata == $past(rv[dx_next]))
    else $error("X store did not use the pre-instruction source");
  dual_cc_a: assert property (move_done && dual_reg && !sw_wr
      |=> rf_reg[move_pkg::IDX_SR][5:0] == $past(rf_reg[move_pkg::IDX_SR][5:0]))
    else $error("dual move changed low condition bits");
  sr_load_a: assert property (move_done && load_sr |=>
      rf_reg[move_pkg::IDX_SR][7:0] == $past(wb_data[7:0]))
    else $error("status write did not load condition bits");
  sp_dec_a: assert property (move_done && dec_reg && !inc && c_dst_reg != move_pkg::IDX_SP
      && !sw_wr |=> rf_reg[move_pkg::IDX_SP] == $past(rf_reg[move_pkg::IDX_SP]) - 24'h000001)
    else $error("stack pointer not decremented after stack read");
  sp_inc_a: assert property (move_done && inc && !dec_reg && !sw_wr
      |=> rf_reg[move_pkg::IDX_SP] == $past(rf_reg[move_pkg::IDX_SP]) + 24'h000001
      && stack_hi_reg[sp_idx] == $past(wb_data))
    else $error("stack pointer not incremented before stack write");
  growth_set_a: assert property (move_done && !load_sr && growth_det && limit_det
      |=> rf_reg[move_pkg::IDX_SR][7:6] == 2'h3)
    else $error("growth or limit flag not set");
endmodule

// [include/move_pkg.sv]
// Shared constants for the dual memory move and control register move block.
// Assumes a 24-bit word core with one 32-entry register index space.
package move_pkg;
  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int IDX_W = 5;
  localparam int SW_ADDR_W = 6;
  localparam int CC_W = 8;
  localparam int SHORT_IMM_W = 8;
  localparam int ABS_SHORT_W = 6;
  typedef logic [WORD_W-1:0] word_t;
  typedef logic [IDX_W-1:0] idx_t;

  // ----------------------------------------------------------------------
  // Register index map (also the software register offsets)
  // ----------------------------------------------------------------------
  localparam idx_t IDX_X0 = 5'h10;
  localparam idx_t IDX_X1 = 5'h11;
  localparam idx_t IDX_Y0 = 5'h12;
  localparam idx_t IDX_Y1 = 5'h13;
  localparam idx_t IDX_A = 5'h14;
  localparam idx_t IDX_B = 5'h15;
  localparam idx_t IDX_SR = 5'h19;
  localparam idx_t IDX_SP = 5'h1B;
  localparam idx_t IDX_SSH = 5'h1C;
  localparam idx_t IDX_SSL = 5'h1D;
  localparam logic [SW_ADDR_W-1:0] SW_STATUS = 6'h20;
  localparam word_t RF_RESET = 24'h000000;

  // ----------------------------------------------------------------------
  // Instruction fields (LSB positions)
  // ----------------------------------------------------------------------
  localparam int F_DUAL = 23;
  localparam int F_YW = 22;
  localparam int F_YMODE = 20;
  localparam int F_EE = 18;
  localparam int F_FF = 16;
  localparam int F_XW = 15;
  localparam int F_YR = 13;
  localparam int F_XMODE = 11;
  localparam int F_PTR = 8;
  localparam int F_FORM = 21;
  localparam int F_CW = 20;
  localparam int F_SPACE = 19;
  localparam int F_CIDX = 14;
  localparam int F_CMODE = 11;
  localparam int F_OIDX = 8;
  localparam int F_ABS = 8;
  localparam int F_IMM = 0;
  localparam int CC_GROWTH = 7;
  localparam int CC_LIMIT = 6;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] FORM_REG = 2'h0;
  localparam logic [1:0] FORM_EA = 2'h1;
  localparam logic [1:0] FORM_ABS = 2'h2;
  localparam logic [1:0] FORM_IMM = 2'h3;
  localparam logic [2:0] EA_PLAIN = 3'h0;
  localparam logic [2:0] EA_POSTINC = 3'h1;
  localparam logic [2:0] EA_POSTDEC = 3'h2;
  localparam logic [2:0] EA_POSTOFS = 3'h3;
  localparam logic [2:0] EA_PREDEC = 3'h4;
  localparam logic [2:0] EA_INDEX = 3'h5;
  localparam logic [2:0] EA_ABS = 3'h6;
  localparam logic [2:0] EA_IMM = 3'h7;
  localparam word_t IO_BASE = 24'hFFFF80;

  typedef enum logic {ST_IDLE, ST_EXEC} state_t;
endpackage

// [include/ea_if.sv]
// Effective address request between the decoder and an address unit.
// Assumes the decoder presents pointer, offset and mode in the same cycle.
`timescale 1ns/1ps
interface ea_if;
  logic [23:0] ptr;
  logic [23:0] offset;
  logic [2:0] mode;
  logic [23:0] ext;
  logic [23:0] addr;
  logic [23:0] ptr_next;
  modport unit (input ptr, input offset, input mode, input ext, output addr, output ptr_next);
  modport user (output ptr, output offset, output mode, output ext, input addr, input ptr_next);
endinterface

// [src/ea_unit.sv]
// Effective address calculation for one pointer.
// Assumes the caller only commits ptr_next for pointer-based modes.
`timescale 1ns/1ps
module ea_unit (
  ea_if.unit ea
);
  always_comb begin
    ea.addr = ea.ptr;
    ea.ptr_next = ea.ptr;
    unique case (ea.mode)
      move_pkg::EA_PLAIN: ea.ptr_next = ea.ptr;
      move_pkg::EA_POSTINC: ea.ptr_next = ea.ptr + 24'h000001;
      move_pkg::EA_POSTDEC: ea.ptr_next = ea.ptr - 24'h000001;
      move_pkg::EA_POSTOFS: ea.ptr_next = ea.ptr + ea.offset;
      move_pkg::EA_PREDEC: begin
        ea.addr = ea.ptr - 24'h000001;
        ea.ptr_next = ea.ptr - 24'h000001;
      end
      move_pkg::EA_INDEX: ea.addr = ea.ptr + ea.offset;
      move_pkg::EA_ABS: ea.addr = ea.ext;
      move_pkg::EA_IMM: ea.addr = ea.ext;
    endcase
  end
endmodule

// [src/cc_unit.sv]
// Condition code byte update for both move kinds.
// Assumes growth and limit detections come from the data path in the move cycle.
`timescale 1ns/1ps
module cc_unit (
  input wire logic [7:0] cc_old,
  input wire logic [7:0] src_byte,
  input wire logic load_all,
  input wire logic growth,
  input wire logic limit,
  output logic [7:0] cc_new
);
  always_comb begin
    if (load_all) begin
      cc_new = src_byte;
    end else begin
      // Growth and limit are sticky; the low six bits pass untouched.
      cc_new = cc_old;
      cc_new[move_pkg::CC_GROWTH] = cc_old[move_pkg::CC_GROWTH] | growth;
      cc_new[move_pkg::CC_LIMIT] = cc_old[move_pkg::CC_LIMIT] | limit;
    end
  end
endmodule

// [dv/xy_mem_model.sv]
// Behavioural X and Y data memories on the far side of the move block.
// Assumes one-cycle read and write strobes from the block.
`timescale 1ns/1ps
module xy_mem_model (
  input wire logic clk_sys,
  input wire logic [23:0] x_addr,
  input wire logic x_rd,
  input wire logic x_wr,
  input wire logic [23:0] x_wdata,
  output logic [23:0] x_rdata,
  input wire logic [23:0] y_addr,
  input wire logic y_rd,
  input wire logic y_wr,
  input wire logic [23:0] y_wdata,
  output logic [23:0] y_rdata
);
  logic [23:0] xm [64];
  logic [23:0] ym [64];
  // Data is inverted off the strobe so a late sample by the block is caught.
  assign x_rdata = x_rd ? xm[x_addr[5:0]] : ~xm[x_addr[5:0]];
  assign y_rdata = y_rd ? ym[y_addr[5:0]] : ~ym[y_addr[5:0]];
  always @(posedge clk_sys) begin
    if (x_wr) xm[x_addr[5:0]] <= x_wdata;
    if (y_wr) ym[y_addr[5:0]] <= y_wdata;
  end
endmodule

// [dv/dual_memory_and_control_move_bench.sv]
// Self-checking bench for the dual memory and control register move block.
// Assumes the memory model answers reads within the strobe cycle.
`timescale 1ns/1ps
module dual_memory_and_control_move_bench;
  logic clk_sys, rst_b = 1'b0, instr_valid = 1'b0, growth_det = 1'b0, limit_det = 1'b0;
  logic sw_wr = 1'b0, sw_rd = 1'b0, instr_ready, move_done, y_io_dropped;
  logic x_mem_rd, x_mem_wr, y_mem_rd, y_mem_wr;
  logic [23:0] instr_word = 24'h0, instr_ext = 24'h0, sw_wdata = 24'h0;
  logic [23:0] x_mem_addr, x_mem_wdata, x_mem_rdata, y_mem_addr, y_mem_wdata, y_mem_rdata;
  logic [23:0] sw_rdata, a, b, c, d;
  logic [5:0] sw_addr = 6'h0;
  logic [2:0] px;
  logic [1:0] yl;
  int n_errors = 0, n_checks = 0;

  dual_memory_and_control_move dut_u (.clk_sys, .rst_b, .instr_valid, .instr_ready,
    .instr_word, .instr_ext, .growth_det, .limit_det, .x_mem_addr, .x_mem_rd, .x_mem_wr,
    .x_mem_wdata, .x_mem_rdata, .y_mem_addr, .y_mem_rd, .y_mem_wr, .y_mem_wdata,
    .y_mem_rdata, .move_done, .y_io_dropped, .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
  xy_mem_model mem_u (.clk_sys, .x_addr(x_mem_addr), .x_rd(x_mem_rd), .x_wr(x_mem_wr),
    .x_wdata(x_mem_wdata), .x_rdata(x_mem_rdata), .y_addr(y_mem_addr), .y_rd(y_mem_rd),
    .y_wr(y_mem_wr), .y_wdata(y_mem_wdata), .y_rdata(y_mem_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic sw_w(input logic [5:0] ad, input logic [23:0] v);
    @(posedge clk_sys);
    sw_wr <= 1'b1;
    sw_addr <= ad;
    sw_wdata <= v;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask

  task automatic sw_chk(input logic [5:0] ad, input logic [23:0] e);
    @(posedge clk_sys);
    sw_rd <= 1'b1;
    sw_addr <= ad;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1;
    chk(sw_rdata, e);
  endtask

  // Leaves the caller inside the execute cycle so strobes can be sampled.
  task automatic exec(input logic [23:0] w, input logic g, input logic l);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    growth_det <= g;
    limit_det <= l;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    chk(24'({move_done, instr_ready}), 24'h2);
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(85));
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    sw_chk(6'h1B, 24'h0);
    sw_w(6'h2A, 24'h123456);
    sw_chk(6'h2A, 24'h0);
    $display("test reset_map done");
    for (int i = 0; i < 4; i++) begin
      px = 3'($urandom);
      yl = 2'($urandom);
      a = 24'($urandom % 32);
      b = 24'(32 + $urandom % 32);
      c = 24'($urandom);
      d = 24'($urandom);
      mem_u.xm[a[5:0]] = ~c;
      mem_u.ym[b[5:0]] = ~d;
      sw_w({3'h0, px}, a);
      sw_w({3'h0, ~px[2], yl}, b);
      sw_w(6'h10, c);
      sw_w(6'h13, d);
      exec({1'b1, i[1], 4'h0, 2'h1, i[0], yl, 2'h0, px, 8'h00}, 1'b0, 1'b0);
      chk(x_mem_addr, a);
      chk(y_mem_addr, b);
      chk(24'({x_mem_rd, x_mem_wr, y_mem_rd, y_mem_wr, y_io_dropped}),
        24'({i[0], !i[0], i[1], !i[1], 1'b0}));
      if (!i[0]) chk(x_mem_wdata, c);
      if (!i[1]) chk(y_mem_wdata, d);
      sw_chk(6'h10, i[0] ? ~c : c);
      sw_chk(6'h13, i[1] ? ~d : d);
    end
    $display("test dual_directions done");
    a = 24'($urandom);
    c = 24'($urandom % 128);
    sw_w(6'h14, a);
    sw_w(6'h19, c);
    exec({1'b1, 1'b0, 2'h0, 2'h2, 2'h2, 1'b0, 2'h0, 2'h0, 3'h0, 8'h00}, 1'b1, 1'b0);
    chk(x_mem_wdata, a);
    chk(y_mem_wdata, a);
    sw_chk(6'h19, c | 24'h80);
    sw_w(6'h02, 24'hFFFF90);
    sw_w(6'h05, 24'hFFFFC0);
    exec({1'b1, 1'b1, 4'h0, 2'h1, 1'b1, 2'h1, 2'h0, 3'h2, 8'h00}, 1'b0, 1'b0);
    chk(24'({x_mem_rd, y_mem_rd, y_mem_wr, y_io_dropped}), 24'h9);
    chk(x_mem_addr, 24'hFFFF90);
    $display("test dual_sources_io done");
    c = 24'($urandom % 256);
    sw_w(6'h10, c);
    exec({4'h1, 1'b0, 5'h19, 6'h10, 8'h00}, 1'b1, 1'b1);
    sw_chk(6'h19, c);
    d = 24'($urandom % 256);
    exec({4'h7, 1'b0, 5'h1C, 6'h00, d[7:0]}, 1'b0, 1'b0);
    sw_chk(6'h1B, 24'h1);
    sw_chk(6'h1C, d);
    exec({4'h0, 1'b0, 5'h1C, 6'h11, 8'h00}, 1'b0, 1'b0);
    sw_chk(6'h11, d);
    sw_chk(6'h1B, 24'h0);
    b = 24'($urandom % 64);
    mem_u.xm[b[5:0]] = a;
    // Clear growth and limit first so that the sticky set is really seen.
    sw_w(6'h19, c & 24'h3F);
    exec({4'h5, 1'b0, 5'h08, b[5:0], 8'h00}, 1'b1, 1'b1);
    chk(x_mem_addr, b);
    sw_chk(6'h08, a);
    sw_chk(6'h19, (c & 24'h3F) | 24'hC0);
    exec({4'h4, 1'b1, 5'h08, b[5:0], 8'h00}, 1'b0, 1'b0);
    chk(24'({y_mem_wr, x_mem_wr}), 24'h2);
    chk(y_mem_wdata, a);
    d = 24'($urandom);
    @(posedge clk_sys);
    instr_ext <= d;
    exec({4'h3, 1'b0, 5'h09, 3'h7, 3'h0, 8'h00}, 1'b0, 1'b0);
    sw_chk(6'h09, d);
    sw_w(6'h03, b);
    mem_u.ym[b[5:0]] = d;
    exec({4'h3, 1'b1, 5'h0A, 3'h1, 3'h3, 8'h00}, 1'b0, 1'b0);
    chk(24'({y_mem_rd, x_mem_rd}), 24'h2);
    chk(y_mem_addr, b);
    sw_chk(6'h0A, d);
    sw_chk(6'h03, b + 24'h000001);
    $display("test control_moves done");
    end_sim();
  end
endmodule
